// [core/fast_comparator_defines.vh]
// Purpose: constants shared by the fast comparator wrapper files
// Assumes: 8-bit byte address space on an AXI4-Lite slave
// Notes: definitions only, no logic
`ifndef FAST_COMPARATOR_DEFINES_VH
`define FAST_COMPARATOR_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FC_ADDR_W 8
`define FC_RESULT_OFS 8'h00
`define FC_IRQ_STATUS_OFS 8'h04
`define FC_IRQ_MASK_OFS 8'h08
`define FC_CFG_BASE_OFS 8'h10

// ----------------------------------------------------------------
// channel config field positions (two bits each)
// ----------------------------------------------------------------
`define FC_CFG_IN_LSB 0
`define FC_CFG_REF_LSB 4
`define FC_CFG_EDGE_LSB 8
`define FC_CFG_FILT_LSB 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FC_SEL_RESET 2'h0
`define FC_MASK_RESET 8'h00
`define FC_STATUS_RESET 8'h00

// ----------------------------------------------------------------
// edge and filter codes
// ----------------------------------------------------------------
`define FC_EDGE_RISE 2'h0
`define FC_EDGE_FALL 2'h1
`define FC_FILT_BYPASS 2'h0
`define FC_FILT_RATE_A 2'h1
`define FC_FILT_RATE_B 2'h2
`define FC_FILT_RATE_C 2'h3

// ----------------------------------------------------------------
// timing: sample period is 2**log2 clock cycles
// ----------------------------------------------------------------
`define FC_RATE_A_LOG2 2
`define FC_RATE_B_LOG2 4
`define FC_RATE_C_LOG2 6
`define FC_PRESCALE_W 6
`define FC_FILTER_LEN 3

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define FC_RESP_OKAY 2'h0
`define FC_RESP_SLVERR 2'h2

`endif

// [core/noise_filter.v]
// Purpose: sample-and-agree noise filter for one comparison result
// Assumes: din synchronous to aclk; sample_en is a one-cycle tick
// Notes: output changes only after FILTER_LEN equal samples unless bypass is set
`default_nettype none
`include "fast_comparator_defines.vh"

module noise_filter #(
  parameter FILTER_LEN = `FC_FILTER_LEN
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire bypass,
  input wire sample_en,
  input wire din,
  output reg dout
);

  // ----------------------------------------------------------------
  // sample history
  // ----------------------------------------------------------------
  reg [FILTER_LEN-1:0] hist_q; // newest sample in bit 0

  // shift on tick, settle when all samples agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hist_q <= {FILTER_LEN{1'b0}};
      dout <= 1'b0;
    end
    else if (ce)
    begin
      if (bypass)
      begin
        // raw result passes, history tracks it to avoid a glitch
        hist_q <= {FILTER_LEN{din}};
        dout <= din;
      end
      else if (sample_en)
      begin
        hist_q <= {hist_q[FILTER_LEN-2:0], din};
        if (&{hist_q[FILTER_LEN-2:0], din})
          dout <= 1'b1;
        else if (~|{hist_q[FILTER_LEN-2:0], din})
          dout <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [core/edge_detect.v]
// Purpose: valid-edge detector giving interrupt and event pulses
// Assumes: din is the filtered or bypassed result
// Notes: first sample after reset is compared against zero
`default_nettype none
`include "fast_comparator_defines.vh"

module edge_detect (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [1:0] edge_sel,
  input wire din,
  output reg irq_pulse,
  output reg event_pulse
);

  // ----------------------------------------------------------------
  // edge logic
  // ----------------------------------------------------------------
  reg prev_q; // last seen result
  reg valid_d; // selected edge seen this cycle
  wire rise = din & ~prev_q;
  wire fall = ~din & prev_q;

  // edge selection: rising, falling, or both
  always @*
  begin
    case (edge_sel)
      `FC_EDGE_RISE: valid_d = rise;
      `FC_EDGE_FALL: valid_d = fall;
      default: valid_d = rise | fall;
    endcase
  end

  // one-cycle pulses per valid edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_q <= 1'b0;
      irq_pulse <= 1'b0;
      event_pulse <= 1'b0;
    end
    else if (ce)
    begin
      prev_q <= din;
      irq_pulse <= valid_d;
      event_pulse <= valid_d;
    end
  end

endmodule
`default_nettype wire

// [core/fast_comparator.v]
// Purpose: digital wrapper of a bank of fast analog comparators
// Assumes: comparator results arrive synchronous to aclk
// Notes: registers over AXI4-Lite; all state frozen while ce is low
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`default_nettype none
`include "fast_comparator_defines.vh"

module fast_comparator #(
  parameter NCH = 4
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [`FC_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [`FC_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [NCH-1:0] cmp_result,
  output reg [4*NCH-1:0] input_source_select,
  output reg [4*NCH-1:0] reference_source_select,
  output reg [NCH-1:0] channel_out,
  output reg shared_compare_out,
  output reg grouped_compare_out,
  output wire [NCH-1:0] irq_pulse,
  output wire [NCH-1:0] event_out,
  output reg irq
);

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam AW = `FC_ADDR_W;
  localparam PW = `FC_PRESCALE_W;
  localparam [7:0] MASK_RST = `FC_MASK_RESET; // sized for widest build
  localparam [7:0] STATUS_RST = `FC_STATUS_RESET;

  // ----------------------------------------------------------------
  // channel configuration state
  // ----------------------------------------------------------------
  reg [2*NCH-1:0] in_sel_q; // analog input code per channel
  reg [2*NCH-1:0] ref_sel_q; // reference code per channel
  reg [2*NCH-1:0] edge_sel_q; // edge choice per channel
  reg [2*NCH-1:0] filt_sel_q; // filter rate or bypass
  reg [NCH-1:0] status_q; // sticky interrupt flags
  reg [NCH-1:0] mask_q; // interrupt enables
  reg [NCH-1:0] status_d; // next sticky flags
  reg [NCH-1:0] clr_d; // write-one-to-clear bits
  reg [PW-1:0] prescale_q; // free running sample divider
  wire [NCH-1:0] filt_out; // filtered or bypassed results
  wire [32*NCH-1:0] cfg_words; // readback view of config

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  reg aw_hold_q; // write address captured
  reg w_hold_q; // write data captured
  reg [AW-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  reg [31:0] wmerge; // merged write word
  wire do_write = aw_hold_q & w_hold_q & ~bvalid;
  wire [AW-1:0] aw_idx = (awaddr_q - `FC_CFG_BASE_OFS) >> 2;
  wire [AW-1:0] ar_idx = (araddr - `FC_CFG_BASE_OFS) >> 2;
  wire aw_cfg = (awaddr_q >= `FC_CFG_BASE_OFS) &&
                (aw_idx < NCH) && (awaddr_q[1:0] == 2'h0);
  wire ar_cfg = (araddr >= `FC_CFG_BASE_OFS) &&
                (ar_idx < NCH) && (araddr[1:0] == 2'h0);
  wire aw_map = aw_cfg || (awaddr_q == `FC_RESULT_OFS) ||
                (awaddr_q == `FC_IRQ_STATUS_OFS) ||
                (awaddr_q == `FC_IRQ_MASK_OFS);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write into an old word
  function [31:0] lane_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] strb;
    integer b;
    begin
      lane_merge = old_w;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          lane_merge[8*b +: 8] = new_w[8*b +: 8];
    end
  endfunction

  // code to one-hot route, so at most one source is ever closed
  function [3:0] onehot4;
    input [1:0] code;
    begin
      case (code)
        2'h0: onehot4 = 4'h1;
        2'h1: onehot4 = 4'h2;
        2'h2: onehot4 = 4'h4;
        default: onehot4 = 4'h8;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // per-channel datapath
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : chan
      reg tick; // sample tick of the chosen rate
      wire [1:0] fsel = filt_sel_q[2*g +: 2];

      // pick one of three sampling rates
      always @*
      begin
        case (fsel)
          `FC_FILT_RATE_A:
            tick = ~|prescale_q[`FC_RATE_A_LOG2-1:0];
          `FC_FILT_RATE_B:
            tick = ~|prescale_q[`FC_RATE_B_LOG2-1:0];
          `FC_FILT_RATE_C:
            tick = ~|prescale_q[`FC_RATE_C_LOG2-1:0];
          default:
            tick = 1'b0;
        endcase
      end

      noise_filter #(
        .FILTER_LEN(`FC_FILTER_LEN)
      ) u_filt (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .bypass(fsel == `FC_FILT_BYPASS),
        .sample_en(tick),
        .din(cmp_result[g]),
        .dout(filt_out[g])
      );

      // edges come after the filter, never from the raw input
      edge_detect u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .edge_sel(edge_sel_q[2*g +: 2]),
        .din(filt_out[g]),
        .irq_pulse(irq_pulse[g]),
        .event_pulse(event_out[g])
      );

      // readback word of this channel
      assign cfg_words[32*g +: 32] = {18'h0_0000, fsel,
        2'h0, edge_sel_q[2*g +: 2], 2'h0, ref_sel_q[2*g +: 2],
        2'h0, in_sel_q[2*g +: 2]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // sample prescaler
  // ----------------------------------------------------------------
  // one shared counter keeps all channels on a common sample grid
  always @(posedge aclk)
  begin
    if (!aresetn)
      prescale_q <= {PW{1'b0}};
    else if (ce)
      prescale_q <= prescale_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // result pins and source routing
  // ----------------------------------------------------------------
  integer c;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_out <= {NCH{1'b0}};
      shared_compare_out <= 1'b0;
      grouped_compare_out <= 1'b0;
      input_source_select <= {4*NCH{1'b0}};
      reference_source_select <= {4*NCH{1'b0}};
    end
    else if (ce)
    begin
      channel_out <= filt_out;
      shared_compare_out <= |filt_out;
      grouped_compare_out <= |filt_out[2:0];
      for (c = 0; c < NCH; c = c + 1)
      begin
        input_source_select[4*c +: 4] <=
          onehot4(in_sel_q[2*c +: 2]);
        reference_source_select[4*c +: 4] <=
          onehot4(ref_sel_q[2*c +: 2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  // a new edge beats a clear in the same cycle
  always @*
  begin
    clr_d = {NCH{1'b0}};
    if (do_write && (awaddr_q == `FC_IRQ_STATUS_OFS) && wstrb_q[0])
      clr_d = wdata_q[NCH-1:0];
    status_d = (status_q & ~clr_d) | irq_pulse;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= STATUS_RST[NCH-1:0];
      irq <= 1'b0;
    end
    else if (ce)
    begin
      status_q <= status_d;
      irq <= |(status_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  always @*
  begin
    wmerge = 32'h0000_0000;
    if (aw_cfg)
      wmerge = lane_merge(cfg_words[32*aw_idx +: 32], wdata_q, wstrb_q);
    else if (awaddr_q == `FC_IRQ_MASK_OFS)
      wmerge = lane_merge({{(32-NCH){1'b0}}, mask_q}, wdata_q, wstrb_q);
  end

  // address and data taken in either order, answer after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `FC_RESP_OKAY;
      in_sel_q <= {NCH{`FC_SEL_RESET}};
      ref_sel_q <= {NCH{`FC_SEL_RESET}};
      edge_sel_q <= {NCH{`FC_SEL_RESET}};
      filt_sel_q <= {NCH{`FC_SEL_RESET}};
      mask_q <= MASK_RST[NCH-1:0];
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_hold_q <= 1'b1;
        awready <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_q <= 1'b1;
        wready <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_map ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
        if (aw_cfg)
        begin
          // software picks codes; amplifier power is its duty
          in_sel_q[2*aw_idx +: 2] <= wmerge[`FC_CFG_IN_LSB +: 2];
          ref_sel_q[2*aw_idx +: 2] <= wmerge[`FC_CFG_REF_LSB +: 2];
          edge_sel_q[2*aw_idx +: 2] <= wmerge[`FC_CFG_EDGE_LSB +: 2];
          filt_sel_q[2*aw_idx +: 2] <= wmerge[`FC_CFG_FILT_LSB +: 2];
        end
        else if (awaddr_q == `FC_IRQ_MASK_OFS)
          mask_q <= wmerge[NCH-1:0];
      end
      else if (bvalid && bready)
      begin
        // reopen both channels only once the answer is gone
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channels
  // ----------------------------------------------------------------
  // read mux; unmapped words read zero with an error answer
  always @*
  begin
    rdata_d = 32'h0000_0000;
    rresp_d = `FC_RESP_OKAY;
    if (ar_cfg)
      rdata_d = cfg_words[32*ar_idx +: 32];
    else if (araddr == `FC_RESULT_OFS)
      rdata_d = {{(16-NCH){1'b0}}, cmp_result,
                 {(16-NCH){1'b0}}, channel_out};
    else if (araddr == `FC_IRQ_STATUS_OFS)
      rdata_d = {{(32-NCH){1'b0}}, status_q};
    else if (araddr == `FC_IRQ_MASK_OFS)
      rdata_d = {{(32-NCH){1'b0}}, mask_q};
    else
      rresp_d = `FC_RESP_SLVERR;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `FC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdata_d;
        rresp <= rresp_d;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/comp_core_model.sv]
// Purpose: behavioural comparator core in front of the wrapper
// Assumes: analog levels given as one digital level per source
// Notes: result high when routed input high and routed ref low
`default_nettype none
module comp_core_model #(
  parameter NCH = 4
)(
  input wire logic [4*NCH-1:0] input_source_select,
  input wire logic [4*NCH-1:0] reference_source_select,
  input wire logic [4*NCH-1:0] ain,
  input wire logic [4*NCH-1:0] aref,
  input wire logic amp_on,
  output logic [NCH-1:0] cmp_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // compare routed input against routed ref
  // ----------------------------------------
  // amplifier source (code 3) reads low while its unit is stopped
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      cmp_result[c] = |(input_source_select[4*c+:4] & ain[4*c+:4] &
        {amp_on, 3'b111}) & ~|(reference_source_select[4*c+:4] &
        aref[4*c+:4]);
    end
  end
endmodule
`default_nettype wire

// [tb/fast_comparator_checker.sv]
// Purpose: port-level assertions for the comparator wrapper
// Assumes: ce only dropped while bus and pulses are idle
// Notes: bound onto every fast_comparator instance
`default_nettype none
`include "fast_comparator_defines.vh"
module fast_comparator_checker #(
  parameter NCH = 4
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [4*NCH-1:0] input_source_select,
  input wire logic [4*NCH-1:0] reference_source_select,
  input wire logic [NCH-1:0] channel_out,
  input wire logic shared_compare_out,
  input wire logic grouped_compare_out,
  input wire logic [NCH-1:0] irq_pulse,
  input wire logic [NCH-1:0] event_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus handshake steps
  // ----------------------------------------
  sequence b_wait; bvalid && !bready; endsequence
  sequence r_wait; rvalid && !rready; endsequence
  sequence r_take; arvalid && arready; endsequence
  b_hold_a: assert property (b_wait |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (r_wait |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (r_take |=> rvalid && !arready)
    else $error("read not answered next cycle");
  busy_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  // ----------------------------------------
  // result pins and pulses
  // ----------------------------------------
  shared_or_a: assert property (shared_compare_out == |channel_out)
    else $error("shared pin not OR of channels");
  grouped_or_a: assert property (
    grouped_compare_out == |channel_out[2:0])
    else $error("grouped pin not OR of channels 0 to 2");
  pulse_event_a: assert property (irq_pulse == event_out)
    else $error("event and interrupt pulses differ");
  // a pulse only where the filtered level really moved
  pulse_cause_a: assert property ((irq_pulse & ~(channel_out ^
    $past(channel_out))) == '0)
    else $error("pulse without result edge");
  // irq rises one edge after a pulse or a mask write
  irq_cause_a: assert property ($rose(irq) |->
    $past(irq_pulse) != '0 || $past(bvalid))
    else $error("irq rose without cause");
  // select outputs need one edge after reset to load
  for (genvar c = 0; c < NCH; c++)
  begin : g_sel
    sel_onehot_a: assert property ($past(aresetn) |->
      $onehot(input_source_select[4*c+:4]) &&
      $onehot(reference_source_select[4*c+:4]))
      else $error("source select not one-hot");
  end
endmodule
bind fast_comparator fast_comparator_checker #(.NCH(NCH)) chk_i (.*);
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the comparator wrapper
// Assumes: registers at the byte offsets of the shared defines
// Notes: one task per scenario, AXI4-Lite master tasks
`default_nettype none
`include "fast_comparator_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, ce = 1; // ce: run unless frozen
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, shared, grouped;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [15:0] isel, rsel, ain = 0, aref = 0;
  logic [3:0] cmp, chout, pulse, evt;
  logic amp_on = 0; // amplifier stopped until software starts it
  int errors = 0, checked = 0, npulse = 0, nev = 0;
  initial forever #10 aclk = ~aclk;
  fast_comparator dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmp_result(cmp),
    .input_source_select(isel), .reference_source_select(rsel),
    .channel_out(chout), .shared_compare_out(shared),
    .grouped_compare_out(grouped), .irq_pulse(pulse), .event_out(evt),
    .irq(irq));
  comp_core_model #(.NCH(4)) core (.input_source_select(isel),
    .reference_source_select(rsel), .ain(ain), .aref(aref),
    .amp_on(amp_on), .cmp_result(cmp));
  // ----------------------------------------
  // pulse counters on channel 1
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (pulse[1] === 1'b1) npulse <= npulse + 1;
    if (evt[1] === 1'b1) nev <= nev + 1;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // ----------------------------------------
  // bus master, entered just after an edge
  // ----------------------------------------
  // lag holds ready low until the answer shows, so it must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input bit lag = 0);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= !lag;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid && !bready) bready <= 1;
    end while (!(bvalid && bready));
  endtask
  task automatic rd_w(input logic [7:0] a, output logic [31:0] d,
      input bit lag = 0);
    araddr <= a; arvalid <= 1; rready <= !lag;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid && !rready) rready <= 1;
    end while (!(rvalid && rready));
    d = rdata;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_w(`FC_IRQ_MASK_OFS, rd); chk("mask", rd, 0);
    rd_w(`FC_CFG_BASE_OFS, rd, 1); chk("cfg0", rd, 0);
    chk("isel", isel, 16'h1111);
    rd_w(8'h0c, rd); chk("hole", rd, 0);
    chk("hole resp", rresp, `FC_RESP_SLVERR);
    wr(8'h0c, 1); chk("hole wr", bresp, `FC_RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_route();
    amp_on <= 1;
    for (int k = 0; k < 4; k++)
    begin
      wr(`FC_CFG_BASE_OFS, k | (k << 4));
      ain[3:0] <= 4'h1 << k; aref[3:0] <= ~(4'h1 << k);
      repeat (4) @(posedge aclk);
      chk("rsel", rsel[3:0], 4'h1 << k);
      chk("ch0 hi", chout[0], 1);
      rd_w(`FC_RESULT_OFS, rd); chk("result", rd, 32'h0001_0001);
      aref[3:0] <= 4'hf;
      repeat (4) @(posedge aclk);
      chk("ch0 lo", chout[0], 0);
    end
    ain <= 16'h1000;
    repeat (4) @(posedge aclk);
    chk("pins ch3", {shared, grouped}, 2'b10);
    ain <= 0;
    $display("test route done");
  endtask
  task automatic t_edge();
    int p0, e0;
    // earlier scenarios left flags on channels 0 and 3
    wr(`FC_IRQ_STATUS_OFS, 15, 1); chk("wr ok", bresp, `FC_RESP_OKAY);
    for (int e = 0; e < 4; e++)
    begin
      wr(`FC_CFG_BASE_OFS + 4, e << 8);
      wr(`FC_IRQ_MASK_OFS, e != 1 ? 2 : 0);
      p0 = npulse; e0 = nev;
      ain[4] <= 1;
      repeat (6) @(posedge aclk);
      ain[4] <= 0;
      repeat (6) @(posedge aclk);
      chk("pulses", npulse - p0, e >= 2 ? 2 : 1);
      chk("events", nev - e0, e >= 2 ? 2 : 1);
      chk("irq", irq, e != 1);
      rd_w(`FC_IRQ_STATUS_OFS, rd); chk("status", rd, 2);
      wr(`FC_IRQ_STATUS_OFS, 2);
      chk("irq clr", irq, 0);
    end
    $display("test edge done");
  endtask
  task automatic t_filter();
    int p;
    for (int f = 1; f < 4; f++)
    begin
      p = 1 << (2 * f);
      wr(`FC_CFG_BASE_OFS + 8, f << 12);
      ain[8] <= 1;
      @(posedge aclk);
      ain[8] <= 0;
      repeat (4 * p + 4) @(posedge aclk);
      chk("glitch", chout[2], 0);
      ain[8] <= 1;
      repeat (4 * p + 4) @(posedge aclk);
      chk("held", {chout[2], grouped}, 2'b11);
      ain[8] <= 0;
      repeat (4 * p + 4) @(posedge aclk);
    end
    wr(`FC_CFG_BASE_OFS + 8, 0);
    ain[8] <= 1;
    repeat (3) @(posedge aclk);
    chk("bypass", chout[2], 1);
    // clock enable low must freeze the result path
    ce <= 0; ain[8] <= 0;
    repeat (4) @(posedge aclk);
    chk("frozen", chout[2], 1);
    ce <= 1;
    repeat (3) @(posedge aclk);
    chk("thawed", chout[2], 0);
    $display("test filter done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_route();
    t_edge();
    t_filter();
    close_out();
  end
  // whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
